/* rtl/frac_phase_pkg.sv */
// Package with register map, field layout and reset values of the fraction/phase bank
package frac_phase_pkg;
    localparam logic [7:0] ADDR_PFRAC0     = 8'h14;
    localparam logic [7:0] ADDR_PFRAC1     = 8'h15;
    localparam logic [7:0] ADDR_PFRAC2     = 8'h16;
    localparam logic [7:0] ADDR_PFRAC3_AUX = 8'h17;
    localparam logic [7:0] ADDR_AUXFRAC_HI = 8'h18;
    localparam logic [7:0] ADDR_AUXMOD_LO  = 8'h19;
    localparam logic [7:0] ADDR_AUXMOD_HI  = 8'h1A;
    localparam logic [7:0] ADDR_PHASE0     = 8'h1B;
    localparam logic [7:0] ADDR_PHASE1     = 8'h1C;
    localparam logic [7:0] ADDR_PHASE2     = 8'h1D;

    localparam int PFRAC_W  = 25;
    localparam int AUX_W    = 14;
    localparam int PHASE_W  = 24;
    localparam int PHASE_EN_BIT = 6;

    localparam logic [7:0] RST_ZERO      = 8'h00;
    localparam logic [7:0] RST_AUXMOD_LO = 8'hE8;
    localparam logic [7:0] RST_AUXMOD_HI = 8'h03;
    localparam logic [7:0] MASK_AUXFRAC_HI = 8'h7F;
    localparam logic [7:0] MASK_AUXMOD_HI  = 8'h7F;

    // Values handed to the divider
    typedef struct packed {
        logic [PFRAC_W-1:0] primary_fraction_value;
        logic [AUX_W-1:0]   auxiliary_fraction_value;
        logic [AUX_W-1:0]   auxiliary_modulus_value;
    } divider_word_t;

    // Phase adjust request
    typedef struct packed {
        logic               phase_shift_enable;
        logic [PHASE_W-1:0] phase_offset;
    } phase_cfg_t;
endpackage : frac_phase_pkg

/* rtl/fractional_divider_phase_regs.sv */
// Fraction, auxiliary modulus and phase-offset register bank with buffered divider hand-over
//
// Overview of operation
// - 25-bit primary fraction over four bytes, reset zero
// - 14-bit auxiliary fraction in 0x17[7:1], 0x18[6:0]
// - Auxiliary modulus, reset low 0xE8, high 0x3
// - Bit 6 of 0x1A enables phase shift
// - Enabled phase shift advances relative to present phase
// - 24-bit phase offset word, three bytes, reset zero
// - Divider values update on integer low byte write
`timescale 1ns/1ps
module fractional_divider_phase_regs (
    input  wire logic                         i_ref_clk,        // 20 MHz clock
    input  wire logic                         i_rst_n,          // Sync reset, active low
    input  wire logic                         i_wr_en,          // Register write strobe
    input  wire logic                         i_rd_en,          // Register read strobe
    input  wire logic [7:0]                   i_addr,           // Register address
    input  wire logic [7:0]                   i_wdata,          // Write data
    input  wire logic                         i_int_low_wr,     // Integer low byte written
    output logic      [7:0]                   o_rdata,          // Read data, registered
    output logic                              o_rd_hit,         // Read address in bank
    output frac_phase_pkg::divider_word_t     o_divider,        // Buffered divider values
    output logic                              o_divider_load,   // Divider values updated
    output frac_phase_pkg::phase_cfg_t        o_phase_cfg,      // Phase adjust settings
    output logic                              o_phase_step,     // Apply relative phase step
    output logic      [frac_phase_pkg::PHASE_W-1:0] o_phase_acc // Accumulated output phase
);

    ////////////////////////////////////////////////////////////////////////////
    // Register storage
    logic [7:0] pfrac0;
    logic [7:0] next_pfrac0;
    logic [7:0] pfrac1;
    logic [7:0] next_pfrac1;
    logic [7:0] pfrac2;
    logic [7:0] next_pfrac2;
    logic [7:0] pfrac3_aux;
    logic [7:0] next_pfrac3_aux;
    logic [7:0] auxfrac_hi;
    logic [7:0] next_auxfrac_hi;
    logic [7:0] auxmod_lo;
    logic [7:0] next_auxmod_lo;
    logic [7:0] auxmod_hi;
    logic [7:0] next_auxmod_hi;
    logic [7:0] phase0;
    logic [7:0] next_phase0;
    logic [7:0] phase1;
    logic [7:0] next_phase1;
    logic [7:0] phase2;
    logic [7:0] next_phase2;

    function automatic logic wr_hit(input logic [7:0] adr);
        wr_hit = i_wr_en && (i_addr == adr);
    endfunction : wr_hit

    ////////////////////////////////////////////////////////////////////////////
    // Primary fraction bits 7:0
    always_comb begin
        next_pfrac0 = pfrac0;
        if (wr_hit(frac_phase_pkg::ADDR_PFRAC0)) begin
            next_pfrac0 = i_wdata;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            pfrac0 <= frac_phase_pkg::RST_ZERO;
        end else begin
            pfrac0 <= next_pfrac0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Primary fraction bits 15:8
    always_comb begin
        next_pfrac1 = pfrac1;
        if (wr_hit(frac_phase_pkg::ADDR_PFRAC1)) begin
            next_pfrac1 = i_wdata;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            pfrac1 <= frac_phase_pkg::RST_ZERO;
        end else begin
            pfrac1 <= next_pfrac1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Primary fraction bits 23:16
    always_comb begin
        next_pfrac2 = pfrac2;
        if (wr_hit(frac_phase_pkg::ADDR_PFRAC2)) begin
            next_pfrac2 = i_wdata;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            pfrac2 <= frac_phase_pkg::RST_ZERO;
        end else begin
            pfrac2 <= next_pfrac2;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Primary fraction bit 24 and auxiliary fraction bits 6:0
    always_comb begin
        next_pfrac3_aux = pfrac3_aux;
        if (wr_hit(frac_phase_pkg::ADDR_PFRAC3_AUX)) begin
            next_pfrac3_aux = i_wdata;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            pfrac3_aux <= frac_phase_pkg::RST_ZERO;
        end else begin
            pfrac3_aux <= next_pfrac3_aux;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Auxiliary fraction bits 13:7, top bit reserved
    always_comb begin
        next_auxfrac_hi = auxfrac_hi;
        if (wr_hit(frac_phase_pkg::ADDR_AUXFRAC_HI)) begin
            next_auxfrac_hi = i_wdata & frac_phase_pkg::MASK_AUXFRAC_HI;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            auxfrac_hi <= frac_phase_pkg::RST_ZERO;
        end else begin
            auxfrac_hi <= next_auxfrac_hi;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Auxiliary modulus bits 7:0
    always_comb begin
        next_auxmod_lo = auxmod_lo;
        if (wr_hit(frac_phase_pkg::ADDR_AUXMOD_LO)) begin
            next_auxmod_lo = i_wdata;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            auxmod_lo <= frac_phase_pkg::RST_AUXMOD_LO;
        end else begin
            auxmod_lo <= next_auxmod_lo;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Auxiliary modulus bits 13:8 and phase shift enable, top bit reserved
    always_comb begin
        next_auxmod_hi = auxmod_hi;
        if (wr_hit(frac_phase_pkg::ADDR_AUXMOD_HI)) begin
            next_auxmod_hi = i_wdata & frac_phase_pkg::MASK_AUXMOD_HI;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            auxmod_hi <= frac_phase_pkg::RST_AUXMOD_HI;
        end else begin
            auxmod_hi <= next_auxmod_hi;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Phase offset bits 7:0
    always_comb begin
        next_phase0 = phase0;
        if (wr_hit(frac_phase_pkg::ADDR_PHASE0)) begin
            next_phase0 = i_wdata;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            phase0 <= frac_phase_pkg::RST_ZERO;
        end else begin
            phase0 <= next_phase0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Phase offset bits 15:8
    always_comb begin
        next_phase1 = phase1;
        if (wr_hit(frac_phase_pkg::ADDR_PHASE1)) begin
            next_phase1 = i_wdata;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            phase1 <= frac_phase_pkg::RST_ZERO;
        end else begin
            phase1 <= next_phase1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Phase offset bits 23:16
    always_comb begin
        next_phase2 = phase2;
        if (wr_hit(frac_phase_pkg::ADDR_PHASE2)) begin
            next_phase2 = i_wdata;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            phase2 <= frac_phase_pkg::RST_ZERO;
        end else begin
            phase2 <= next_phase2;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register read port
    logic [7:0] next_rdata;
    logic       next_rd_hit;

    always_comb begin
        next_rd_hit = 1'b1;
        case (i_addr)
            frac_phase_pkg::ADDR_PFRAC0:     next_rdata = pfrac0;
            frac_phase_pkg::ADDR_PFRAC1:     next_rdata = pfrac1;
            frac_phase_pkg::ADDR_PFRAC2:     next_rdata = pfrac2;
            frac_phase_pkg::ADDR_PFRAC3_AUX: next_rdata = pfrac3_aux;
            frac_phase_pkg::ADDR_AUXFRAC_HI: next_rdata = auxfrac_hi;
            frac_phase_pkg::ADDR_AUXMOD_LO:  next_rdata = auxmod_lo;
            frac_phase_pkg::ADDR_AUXMOD_HI:  next_rdata = auxmod_hi;
            frac_phase_pkg::ADDR_PHASE0:     next_rdata = phase0;
            frac_phase_pkg::ADDR_PHASE1:     next_rdata = phase1;
            frac_phase_pkg::ADDR_PHASE2:     next_rdata = phase2;
            default: begin
                next_rdata  = 8'h00;
                next_rd_hit = 1'b0;
            end
        endcase
        if (!i_rd_en) begin
            next_rdata  = o_rdata;
            next_rd_hit = o_rd_hit;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_rdata  <= 8'h00;
            o_rd_hit <= 1'b0;
        end else begin
            o_rdata  <= next_rdata;
            o_rd_hit <= next_rd_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Double buffer toward the divider and relative phase stepping
    // Hand-over takes the values held before the trigger edge
    frac_phase_pkg::divider_word_t      shadow_word;
    frac_phase_pkg::divider_word_t      next_divider;
    frac_phase_pkg::phase_cfg_t         next_phase_cfg;
    logic                               next_divider_load;
    logic                               next_phase_step;
    logic [frac_phase_pkg::PHASE_W-1:0] next_phase_acc;

    always_comb begin
        shadow_word.primary_fraction_value   = {pfrac3_aux[0], pfrac2, pfrac1, pfrac0};
        shadow_word.auxiliary_fraction_value = {auxfrac_hi[6:0], pfrac3_aux[7:1]};
        shadow_word.auxiliary_modulus_value  = {auxmod_hi[5:0], auxmod_lo};
        next_phase_cfg.phase_shift_enable    = auxmod_hi[frac_phase_pkg::PHASE_EN_BIT];
        next_phase_cfg.phase_offset          = {phase2, phase1, phase0};
        next_divider      = i_int_low_wr ? shadow_word : o_divider;
        next_divider_load = i_int_low_wr;
        // Step taken with the buffered update so phase moves with new settings
        next_phase_step   = i_int_low_wr && next_phase_cfg.phase_shift_enable;
        next_phase_acc    = next_phase_step ? o_phase_acc + next_phase_cfg.phase_offset
                                            : o_phase_acc;
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_divider.primary_fraction_value   <= '0;
            o_divider.auxiliary_fraction_value <= '0;
            o_divider.auxiliary_modulus_value  <= {frac_phase_pkg::RST_AUXMOD_HI[5:0],
                                                   frac_phase_pkg::RST_AUXMOD_LO};
            o_divider_load <= 1'b0;
            o_phase_cfg    <= '0;
            o_phase_step   <= 1'b0;
            o_phase_acc    <= '0;
        end else begin
            o_divider      <= next_divider;
            o_divider_load <= next_divider_load;
            o_phase_cfg    <= next_phase_cfg;
            o_phase_step   <= next_phase_step;
            o_phase_acc    <= next_phase_acc;
        end
    end

endmodule : fractional_divider_phase_regs

/* sim/frac_phase_host.sv */
// Host model driving the register port and the integer-low-byte trigger
`timescale 1ns/1ps
module frac_phase_host (
    input  wire logic       i_ref_clk,    // Bank clock
    input  wire logic [7:0] i_rdata,      // Read data
    input  wire logic       i_rd_hit,     // Read in bank
    output logic            o_wr_en,      // Write strobe
    output logic            o_rd_en,      // Read strobe
    output logic      [7:0] o_addr,       // Address
    output logic      [7:0] o_wdata,      // Write data
    output logic            o_int_low_wr  // Integer low byte written
);
    initial {o_wr_en, o_rd_en, o_int_low_wr, o_addr, o_wdata} = '0;
    // Released lines show the inverse of their last value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_ref_clk) #1 {o_wr_en, o_addr, o_wdata} = {1'b1, a, d};
        @(posedge i_ref_clk) #1 {o_wr_en, o_addr, o_wdata} = {1'b0, ~a, ~d};
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
        @(posedge i_ref_clk) #1 {o_rd_en, o_addr} = {1'b1, a};
        @(posedge i_ref_clk) #1 {o_rd_en, o_addr} = {1'b0, ~a};
        d = i_rdata;
        h = i_rd_hit;
    endtask : rd
    // Integer low byte written last, n edges in a row
    task automatic trig(input int n);
        @(posedge i_ref_clk) #1 o_int_low_wr = 1'b1;
        repeat (n) @(posedge i_ref_clk);
        #1 o_int_low_wr = 1'b0;
    endtask : trig
endmodule : frac_phase_host

/* sim/frac_phase_asserts.sv */
// Assertion checker for the fraction and phase register bank
`timescale 1ns/1ps
module frac_phase_chk (
    input wire logic                          i_ref_clk,
    input wire logic                          i_rst_n,
    input wire logic                          i_rd_en,
    input wire logic [7:0]                    i_addr,
    input wire logic                          i_int_low_wr,
    input wire logic [7:0]                    o_rdata,
    input wire logic                          o_rd_hit,
    input wire frac_phase_pkg::divider_word_t o_divider,
    input wire logic                          o_divider_load,
    input wire frac_phase_pkg::phase_cfg_t    o_phase_cfg,
    input wire logic                          o_phase_step,
    input wire logic [frac_phase_pkg::PHASE_W-1:0] o_phase_acc
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    logic in_bank;
    assign in_bank = (i_addr >= 8'h14) && (i_addr <= 8'h1D);
    a_load_on_trig: assert property (i_int_low_wr |=> o_divider_load)
        else $error("divider load missing");
    a_no_stray_load: assert property (!i_int_low_wr |=> !o_divider_load)
        else $error("stray divider load");
    a_div_held: assert property (!i_int_low_wr |=> $stable(o_divider))
        else $error("divider changed without trigger");
    a_step_cause: assert property (o_phase_step |-> $past(i_int_low_wr) && o_phase_cfg.phase_shift_enable)
        else $error("phase step without enabled trigger");
    a_acc_adds: assert property (o_phase_step |-> o_phase_acc == $past(o_phase_acc) + o_phase_cfg.phase_offset)
        else $error("phase not advanced by offset");
    a_acc_held: assert property (!o_phase_step |-> $stable(o_phase_acc))
        else $error("phase moved without step");
    a_rd_miss: assert property (i_rd_en && !in_bank |=> o_rdata == 8'h00 && !o_rd_hit)
        else $error("unmapped read not zero");
    a_rd_hit: assert property (i_rd_en |=> o_rd_hit == $past(in_bank))
        else $error("read hit flag wrong");
    a_rsv_zero: assert property (i_rd_en && (i_addr == 8'h18 || i_addr == 8'h1A) |=> !o_rdata[7])
        else $error("reserved bit reads one");
endmodule : frac_phase_chk
bind fractional_divider_phase_regs frac_phase_chk frac_phase_chk_i (.i_ref_clk, .i_rst_n,
    .i_rd_en, .i_addr, .i_int_low_wr, .o_rdata, .o_rd_hit, .o_divider, .o_divider_load,
    .o_phase_cfg, .o_phase_step, .o_phase_acc);

/* sim/tb.sv */
// Testbench for the fraction and phase register bank
`timescale 1ns/1ps
module tb;
    logic ref_clk = 1'b0, rst_n = 1'b0, wr_en, rd_en, int_low_wr, rd_hit, dl, ps, h;
    logic [7:0] addr, wdata, rdata, d;
    logic [23:0] acc;
    frac_phase_pkg::divider_word_t dv;
    frac_phase_pkg::phase_cfg_t pc;
    int err_total = 0, check_count = 0, cycles = 0;
    localparam logic [7:0] RVAL [10] = '{0, 0, 0, 0, 0, 8'hE8, 8'h03, 0, 0, 0};
    localparam logic [7:0] FVAL [10] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'h7F,
                                        8'hFF, 8'hFF, 8'hFF};
    always #25 ref_clk = ~ref_clk;
    frac_phase_host frac_phase_host_i (.i_ref_clk(ref_clk), .i_rdata(rdata), .i_rd_hit(rd_hit),
        .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata),
        .o_int_low_wr(int_low_wr));
    fractional_divider_phase_regs fractional_divider_phase_regs_i (.i_ref_clk(ref_clk),
        .i_rst_n(rst_n), .i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr), .i_wdata(wdata),
        .i_int_low_wr(int_low_wr), .o_rdata(rdata), .o_rd_hit(rd_hit), .o_divider(dv),
        .o_divider_load(dl), .o_phase_cfg(pc), .o_phase_step(ps), .o_phase_acc(acc));
    task automatic chk(input string n, input logic [52:0] g, input logic [52:0] e);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : tally_and_finish
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            tally_and_finish();
        end
    end
    task automatic rdall(input logic [7:0] t [10]);
        for (int i = 0; i < 10; i++) begin
            frac_phase_host_i.rd(8'h14 + 8'(i), d, h);
            chk("register", 53'({h, d}), 53'({1'b1, t[i]}));
        end
    endtask : rdall
    task automatic after_trig(input logic [52:0] e_dv, input logic s, input logic [23:0] e_acc);
        chk("divider", dv, e_dv);
        chk("load", 53'(dl), 53'(1'b1));
        chk("step", 53'(ps), 53'(s));
        chk("phase acc", 53'(acc), 53'(e_acc));
    endtask : after_trig
    initial begin
        repeat (8) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        rdall(RVAL);
        chk("divider reset", dv, {25'h0, 14'h0, 14'h03E8});
        for (int i = 0; i < 10; i++) frac_phase_host_i.wr(8'h14 + 8'(i), 8'hFF);
        frac_phase_host_i.wr(8'h1E, 8'h55);
        chk("divider held", dv, {25'h0, 14'h0, 14'h03E8});
        rdall(FVAL);
        frac_phase_host_i.rd(8'h13, d, h);
        chk("unmapped", 53'({h, d}), 53'(0));
        frac_phase_host_i.rd(8'h1E, d, h);
        chk("unmapped", 53'({h, d}), 53'(0));
        chk("phase cfg", 53'(pc), 53'({1'b1, 24'hFFFFFF}));
        frac_phase_host_i.trig(1);
        after_trig({25'h1FFFFFF, 14'h3FFF, 14'h3FFF}, 1'b1, 24'hFFFFFF);
        frac_phase_host_i.trig(2);
        after_trig({25'h1FFFFFF, 14'h3FFF, 14'h3FFF}, 1'b1, 24'hFFFFFD);
        frac_phase_host_i.wr(8'h1B, 8'h10);
        frac_phase_host_i.wr(8'h1C, 8'h00);
        frac_phase_host_i.wr(8'h1D, 8'h00);
        frac_phase_host_i.trig(1);
        after_trig({25'h1FFFFFF, 14'h3FFF, 14'h3FFF}, 1'b1, 24'h00000D);
        frac_phase_host_i.wr(8'h1A, 8'h05);
        frac_phase_host_i.wr(8'h14, 8'h3C);
        frac_phase_host_i.wr(8'h17, 8'hA5);
        frac_phase_host_i.trig(1);
        after_trig({25'h1FFFF3C, 14'h3FD2, 14'h05FF}, 1'b0, 24'h00000D);
        tally_and_finish();
    end
endmodule : tb
